// ---- design/sfpe_seq.sv ----
// serial flash program/erase command sequencer with self-timed busy cycle
//
// Overview of operation
// [R01] opcode 12h always takes 32-bit address
// [R02] quad program needs quad enable, four lanes
// [R03] quad program needs write enable latch set
// [R04] quad program loads 1..256 bytes like single
// [R05] host keeps select low through program
// [R06] other opcodes: 24 or 32 bits by mode
// [R07] opcode 34h always takes 32-bit address
// [R08] opcode 20h erases addressed 4 KB sector
// [R09] opcode 21h always takes 32-bit address
// [R10] opcode 52h erases addressed 32 KB block
// [R11] opcode D8h erases addressed 64 KB block
// [R12] opcode DCh always takes 32-bit address
// [R13] C7h or 60h erases whole array
// [R14] erase ignored unless write enable latch set
// [R15] select must rise right after last address bit
// [R16] chip erase: select rises right after opcode
// [R17] busy high for whole self-timed erase
// [R18] status read still served while busy
// [R19] cycle end clears write enable latch
// [R20] protected sector or block is not erased
// [R21] any protection blocks chip erase
// [R22] page address wraps inside 256 bytes
// [R23] program cycle: busy, then latch cleared
// [R24] low address bits ignored for erase regions
// [R25] program/erase ignored while busy
`timescale 1ns/1ns
`default_nettype none
module sfpe_seq #(
	parameter int unsigned PP_CYCLES   = 32'(sfpe_pkg::PP_CYC),
	parameter int unsigned SE_CYCLES   = 32'(sfpe_pkg::SE_CYC),
	parameter int unsigned BE32_CYCLES = 32'(sfpe_pkg::BE32_CYC),
	parameter int unsigned BE64_CYCLES = 32'(sfpe_pkg::BE64_CYC),
	parameter int unsigned CE_CYCLES   = 32'(sfpe_pkg::CE_CYC)
) (
	input  wire logic                       clk,
	input  wire logic                       rst_b,
	input  wire logic                       cs_b,
	input  wire logic                       sck,
	input  wire logic [3:0]                 io_in,
	output logic      [3:0]                 io_out,
	output logic      [3:0]                 io_oe,
	input  wire logic                       four_byte_mode,
	input  wire logic                       quad_io_enable,
	input  wire logic                       protect_complement,
	input  wire logic                       protect_top_bottom,
	input  wire logic                       protect_level_bit3,
	input  wire logic                       protect_level_bit2,
	input  wire logic                       protect_level_bit1,
	input  wire logic                       protect_level_bit0,
	input  wire logic                       lock_hit,
	output var  sfpe_pkg::sfpe_lock_query_s lock_query,
	output var  sfpe_pkg::sfpe_erase_s      erase_cmd,
	output var  sfpe_pkg::sfpe_mem_wr_s     mem_wr,
	output logic                            busy,
	output logic                            write_enable_latch
);
	logic [1:0]            cs_s;
	logic [2:0]            sck_s;
	logic [3:0]            io_s0;
	logic [3:0]            io_s1;
	logic                  cs_hi;
	logic                  cs_rise;
	logic                  sck_rise;
	logic                  sck_fall;
	sfpe_pkg::sfpe_state_e state_r;
	sfpe_pkg::sfpe_cmd_s   cmd_r;
	sfpe_pkg::sfpe_cmd_s   dec;
	logic [5:0]            cnt_r;
	logic [5:0]            cnt_nxt;
	logic [5:0]            alen_r;
	logic [31:0]           sh_r;
	logic [31:0]           sh_nxt;
	logic [31:0]           addr_r;
	logic [31:0]           addr_nxt;
	logic [7:0]            ptr_r;
	logic                  has_data_r;
	logic                  op_ok;
	logic                  byte_done;
	logic                  cmd_done;
	logic                  start_cycle;
	logic                  prot_hit;
	logic [31:0]           tmr_r;
	logic [8:0]            walk_r;
	logic                  cycle_done;
	logic [7:0]            buf_r [256];
	logic [255:0]          loaded_r;
	logic [2:0]            scnt_r;
	logic [7:0]            stat;

	function automatic sfpe_pkg::sfpe_cmd_s decode(input logic [7:0] op);
		decode = '{sfpe_pkg::K_NONE, sfpe_pkg::RG_PAGE, 1'b0, 1'b0};
		case (op)
			sfpe_pkg::OP_PP:      decode.kind = sfpe_pkg::K_PROG;
			sfpe_pkg::OP_PP4:     decode = '{sfpe_pkg::K_PROG, sfpe_pkg::RG_PAGE, 1'b0, 1'b1}; // R01
			sfpe_pkg::OP_QPP:     decode = '{sfpe_pkg::K_PROG, sfpe_pkg::RG_PAGE, 1'b1, 1'b0}; // R04
			sfpe_pkg::OP_QPP4:    decode = '{sfpe_pkg::K_PROG, sfpe_pkg::RG_PAGE, 1'b1, 1'b1}; // R07
			sfpe_pkg::OP_SE:      decode = '{sfpe_pkg::K_ERASE, sfpe_pkg::RG_SECTOR, 1'b0, 1'b0}; // R08
			sfpe_pkg::OP_SE4:     decode = '{sfpe_pkg::K_ERASE, sfpe_pkg::RG_SECTOR, 1'b0, 1'b1}; // R09
			sfpe_pkg::OP_BE32:    decode = '{sfpe_pkg::K_ERASE, sfpe_pkg::RG_BLK32, 1'b0, 1'b0}; // R10
			sfpe_pkg::OP_BE64:    decode = '{sfpe_pkg::K_ERASE, sfpe_pkg::RG_BLK64, 1'b0, 1'b0}; // R11
			sfpe_pkg::OP_BE64_4:  decode = '{sfpe_pkg::K_ERASE, sfpe_pkg::RG_BLK64, 1'b0, 1'b1}; // R12
			sfpe_pkg::OP_CE,
			sfpe_pkg::OP_CE_ALT:  decode = '{sfpe_pkg::K_ERASE, sfpe_pkg::RG_CHIP, 1'b0, 1'b0}; // R13
			sfpe_pkg::OP_WR_EN:   decode.kind = sfpe_pkg::K_WR_EN;
			sfpe_pkg::OP_WR_DIS:  decode.kind = sfpe_pkg::K_WR_DIS;
			sfpe_pkg::OP_RD_STAT: decode.kind = sfpe_pkg::K_RD_STAT;
			default:              decode.kind = sfpe_pkg::K_NONE;
		endcase
	endfunction

	function automatic logic [31:0] cycles_for(input sfpe_pkg::sfpe_region_e r);
		case (r)
			sfpe_pkg::RG_PAGE:   cycles_for = PP_CYCLES;
			sfpe_pkg::RG_SECTOR: cycles_for = SE_CYCLES;
			sfpe_pkg::RG_BLK32:  cycles_for = BE32_CYCLES;
			sfpe_pkg::RG_BLK64:  cycles_for = BE64_CYCLES;
			default:             cycles_for = CE_CYCLES;
		endcase
	endfunction

	// pins come from the host clock domain: two flops before any use
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cs_s  <= 2'h3;
			sck_s <= 3'h0;
			io_s0 <= 4'h0;
			io_s1 <= 4'h0;
		end else begin
			cs_s  <= {cs_s[0], cs_b};
			sck_s <= {sck_s[1:0], sck};
			io_s0 <= io_in;
			io_s1 <= io_s0;
		end
	end

	logic cs_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cs_q <= 1'b1;
		end else begin
			cs_q <= cs_s[1];
		end
	end

	assign cs_hi    = cs_s[1];
	assign cs_rise  = cs_s[1] && !cs_q;
	assign sck_rise = sck_s[1] && !sck_s[2];
	assign sck_fall = !sck_s[1] && sck_s[2];

	always_comb begin
		if (state_r != sfpe_pkg::ST_OP && cmd_r.quad) begin
			sh_nxt  = {sh_r[27:0], io_s1};                                      // R02
			cnt_nxt = cnt_r + 6'h4;
		end else begin
			sh_nxt  = {sh_r[30:0], io_s1[0]};
			cnt_nxt = cnt_r + 6'h1;
		end
		addr_nxt = (alen_r == sfpe_pkg::ADDR_BITS_3B) ? {8'h00, sh_nxt[23:0]} : sh_nxt;
		dec = decode(sh_nxt[7:0]);
		case (dec.kind)
			sfpe_pkg::K_RD_STAT: op_ok = 1'b1;                                 // R18
			sfpe_pkg::K_WR_EN,
			sfpe_pkg::K_WR_DIS:  op_ok = !busy;
			sfpe_pkg::K_PROG:    op_ok = !busy && write_enable_latch
			                             && (!dec.quad || quad_io_enable);     // R02 R03 R25
			sfpe_pkg::K_ERASE:   op_ok = !busy && write_enable_latch;          // R14 R25
			default:             op_ok = 1'b0;
		endcase
		byte_done = !cs_hi && sck_rise && state_r == sfpe_pkg::ST_DATA
		            && cnt_nxt == sfpe_pkg::BYTE_BITS;
	end

	// frame decoder: opcode, address and data shifting on sampled clock rises
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r    <= sfpe_pkg::ST_IDLE;
			cmd_r      <= '{sfpe_pkg::K_NONE, sfpe_pkg::RG_PAGE, 1'b0, 1'b0};
			cnt_r      <= 6'h0;
			alen_r     <= sfpe_pkg::ADDR_BITS_3B;
			sh_r       <= 32'h0;
			addr_r     <= 32'h0;
			ptr_r      <= 8'h0;
			has_data_r <= 1'b0;
			lock_query <= '{32'h0, sfpe_pkg::RG_PAGE};
		end else if (cs_hi) begin
			state_r <= sfpe_pkg::ST_IDLE;
		end else if (state_r == sfpe_pkg::ST_IDLE) begin
			state_r    <= sfpe_pkg::ST_OP;
			cnt_r      <= 6'h0;
			sh_r       <= 32'h0;
			has_data_r <= 1'b0;
			cmd_r      <= '{sfpe_pkg::K_NONE, sfpe_pkg::RG_PAGE, 1'b0, 1'b0};
		end else if (sck_rise) begin
			case (state_r)
				sfpe_pkg::ST_OP: begin
					sh_r  <= sh_nxt;
					cnt_r <= cnt_nxt;
					if (cnt_r[2:0] == sfpe_pkg::OP_LAST_BIT) begin
						cmd_r <= dec;
						cnt_r <= 6'h0;
						sh_r  <= 32'h0;
						alen_r <= (dec.fixed4 || four_byte_mode) ?
						          sfpe_pkg::ADDR_BITS_4B : sfpe_pkg::ADDR_BITS_3B; // R01 R06
						lock_query <= '{32'h0, dec.region};
						if (!op_ok) begin
							state_r <= sfpe_pkg::ST_SKIP;
						end else if (dec.kind == sfpe_pkg::K_RD_STAT) begin
							state_r <= sfpe_pkg::ST_STAT;
						end else if (dec.kind != sfpe_pkg::K_PROG
						             && (dec.kind != sfpe_pkg::K_ERASE
						             || dec.region == sfpe_pkg::RG_CHIP)) begin
							state_r <= sfpe_pkg::ST_EDONE;                       // R16
						end else begin
							state_r <= sfpe_pkg::ST_ADDR;
						end
					end
				end
				sfpe_pkg::ST_ADDR: begin
					sh_r  <= sh_nxt;
					cnt_r <= cnt_nxt;
					if (cnt_nxt == alen_r) begin
						addr_r     <= addr_nxt;
						ptr_r      <= addr_nxt[7:0];
						cnt_r      <= 6'h0;
						lock_query <= '{addr_nxt, cmd_r.region};
						state_r    <= (cmd_r.kind == sfpe_pkg::K_PROG) ?
						              sfpe_pkg::ST_DATA : sfpe_pkg::ST_EDONE;    // R15
					end
				end
				sfpe_pkg::ST_DATA: begin
					sh_r  <= sh_nxt;
					cnt_r <= cnt_nxt;
					if (byte_done) begin
						cnt_r      <= 6'h0;
						has_data_r <= 1'b1;
						// natural 8-bit wrap keeps the pointer inside the page
						ptr_r      <= ptr_r + 8'h1;                              // R22
					end
				end
				// any clock after the exact end disqualifies the command
				sfpe_pkg::ST_EDONE: state_r <= sfpe_pkg::ST_SKIP;               // R15 R16
				default:            state_r <= state_r;
			endcase
		end
	end

	sfpe_prot u_prot (
		.addr   (addr_r),
		.region (cmd_r.region),
		.invert (protect_complement),
		.bottom (protect_top_bottom),
		.level  ({protect_level_bit3, protect_level_bit2, protect_level_bit1, protect_level_bit0}),
		.hit    (prot_hit)
	);

	always_comb begin
		cmd_done = cs_rise && (state_r == sfpe_pkg::ST_EDONE
		           || (state_r == sfpe_pkg::ST_DATA && has_data_r && cnt_r == 6'h0)); // R05 R15
		start_cycle = cmd_done && !prot_hit && !lock_hit                          // R20 R21
		              && (cmd_r.kind == sfpe_pkg::K_PROG || cmd_r.kind == sfpe_pkg::K_ERASE);
		cycle_done  = busy && tmr_r == 32'h0 && walk_r[8];
	end

	// page buffer: later bytes to the same offset overwrite earlier ones
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			loaded_r <= '0;
			for (int i = 0; i < 256; i++) begin
				buf_r[i] <= 8'hFF;
			end
		end else if (state_r == sfpe_pkg::ST_ADDR && cmd_r.kind == sfpe_pkg::K_PROG) begin
			loaded_r <= '0;
		end else if (byte_done) begin
			buf_r[ptr_r]    <= sh_nxt[7:0];                                       // R22 R04
			loaded_r[ptr_r] <= 1'b1;
		end
	end

	// self-timed cycle: busy stays up until the time is spent and the page is written
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy   <= 1'b0;
			tmr_r  <= 32'h0;
			walk_r <= 9'h100;
		end else if (start_cycle) begin
			busy   <= 1'b1;                                                        // R17 R23
			tmr_r  <= cycles_for(cmd_r.region) - 32'h1;
			walk_r <= (cmd_r.kind == sfpe_pkg::K_PROG) ? 9'h000 : 9'h100;
		end else if (busy) begin
			if (tmr_r != 32'h0) begin
				tmr_r <= tmr_r - 32'h1;
			end
			if (!walk_r[8]) begin
				walk_r <= walk_r + 9'h001;
			end
			if (cycle_done) begin
				busy <= 1'b0;                                                      // R17
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			erase_cmd <= '{1'b0, sfpe_pkg::RG_PAGE, 32'h0};
			mem_wr    <= '{1'b0, 32'h0, 8'h00};
		end else begin
			erase_cmd.valid  <= start_cycle && cmd_r.kind == sfpe_pkg::K_ERASE;   // R08 R10 R11 R13
			erase_cmd.region <= cmd_r.region;
			erase_cmd.base   <= addr_r & ~sfpe_pkg::sfpe_region_mask(cmd_r.region); // R24
			mem_wr.valid     <= busy && !walk_r[8] && loaded_r[walk_r[7:0]];
			mem_wr.addr      <= {addr_r[31:8], walk_r[7:0]};
			mem_wr.data      <= buf_r[walk_r[7:0]];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			write_enable_latch <= 1'b0;
		end else if (cmd_done && cmd_r.kind == sfpe_pkg::K_WR_EN) begin
			write_enable_latch <= 1'b1;
		end else if (cmd_done && cmd_r.kind == sfpe_pkg::K_WR_DIS) begin
			write_enable_latch <= 1'b0;
		end else if (cycle_done) begin
			write_enable_latch <= 1'b0;                                            // R19 R23
		end
	end

	always_comb begin
		stat = 8'h00;
		stat[sfpe_pkg::STAT_BUSY_BIT]  = busy;
		stat[sfpe_pkg::STAT_LATCH_BIT] = write_enable_latch;
	end

	// status is sampled live per bit so a poll sees busy drop mid-stream
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			io_out <= 4'h0;
			io_oe  <= 4'h0;
			scnt_r <= 3'h0;
		end else if (cs_hi || state_r != sfpe_pkg::ST_STAT) begin
			io_out <= 4'h0;
			io_oe  <= 4'h0;
			scnt_r <= 3'h0;
		end else if (sck_fall) begin
			io_out <= {2'h0, stat[3'h7 - scnt_r], 1'b0};                        // R18
			io_oe  <= 4'h2;
			scnt_r <= scnt_r + 3'h1;
		end
	end
endmodule
`default_nettype wire

// ---- design/sfpe_pkg.sv ----
// package: opcodes, field positions, timing constants and types of the program/erase sequencer
package sfpe_pkg;

	localparam int          CLK_PERIOD_NS = 10;
	localparam int unsigned ARRAY_AW      = 26;

	localparam logic [7:0] OP_PP       = 8'h02;
	localparam logic [7:0] OP_PP4      = 8'h12;
	localparam logic [7:0] OP_QPP      = 8'h32;
	localparam logic [7:0] OP_QPP4     = 8'h34;
	localparam logic [7:0] OP_SE       = 8'h20;
	localparam logic [7:0] OP_SE4      = 8'h21;
	localparam logic [7:0] OP_BE32     = 8'h52;
	localparam logic [7:0] OP_BE64     = 8'hD8;
	localparam logic [7:0] OP_BE64_4   = 8'hDC;
	localparam logic [7:0] OP_CE       = 8'hC7;
	localparam logic [7:0] OP_CE_ALT   = 8'h60;
	localparam logic [7:0] OP_WR_EN    = 8'h06;
	localparam logic [7:0] OP_WR_DIS   = 8'h04;
	localparam logic [7:0] OP_RD_STAT  = 8'h05;

	localparam logic [5:0] ADDR_BITS_3B = 6'h18;
	localparam logic [5:0] ADDR_BITS_4B = 6'h20;
	localparam logic [5:0] BYTE_BITS    = 6'h08;
	localparam logic [2:0] OP_LAST_BIT  = 3'h7;

	localparam int STAT_BUSY_BIT  = 0;
	localparam int STAT_LATCH_BIT = 1;

	localparam int PAGE_LG   = 8;
	localparam int SECTOR_LG = 12;
	localparam int BLK32_LG  = 15;
	localparam int BLK64_LG  = 16;

	// protection levels at or above this cover all 64 KB blocks
	localparam logic [3:0]  PROT_LVL_CAP   = 4'hB;
	localparam logic [10:0] PROT_ALL_BLKS  = 11'h400;
	localparam logic [26:0] ARRAY_END      = 27'h4000000;

	localparam longint unsigned PAGE_PROGRAM_TIME_US     = 64'd800;
	localparam longint unsigned SECTOR_ERASE_TIME_US     = 64'd50000;
	localparam longint unsigned BLOCK32_ERASE_TIME_US    = 64'd150000;
	localparam longint unsigned LARGE_BLOCK_ERASE_TIME_US = 64'd200000;
	localparam longint unsigned CHIP_ERASE_TIME_US       = 64'd40000000;

	localparam longint unsigned PP_CYC   = PAGE_PROGRAM_TIME_US * 64'd1000 / CLK_PERIOD_NS;
	localparam longint unsigned SE_CYC   = SECTOR_ERASE_TIME_US * 64'd1000 / CLK_PERIOD_NS;
	localparam longint unsigned BE32_CYC = BLOCK32_ERASE_TIME_US * 64'd1000 / CLK_PERIOD_NS;
	localparam longint unsigned BE64_CYC = LARGE_BLOCK_ERASE_TIME_US * 64'd1000 / CLK_PERIOD_NS;
	localparam longint unsigned CE_CYC   = CHIP_ERASE_TIME_US * 64'd1000 / CLK_PERIOD_NS;

	typedef enum logic [2:0] {K_NONE, K_PROG, K_ERASE, K_WR_EN, K_WR_DIS, K_RD_STAT} sfpe_kind_e;
	typedef enum logic [2:0] {RG_PAGE, RG_SECTOR, RG_BLK32, RG_BLK64, RG_CHIP} sfpe_region_e;
	typedef enum logic [2:0] {ST_IDLE, ST_OP, ST_ADDR, ST_DATA, ST_EDONE, ST_STAT, ST_SKIP} sfpe_state_e;

	typedef struct packed {
		sfpe_kind_e   kind;
		sfpe_region_e region;
		logic         quad;
		logic         fixed4;
	} sfpe_cmd_s;

	typedef struct packed {
		logic         valid;
		sfpe_region_e region;
		logic [31:0]  base;
	} sfpe_erase_s;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic [7:0]  data;
	} sfpe_mem_wr_s;

	typedef struct packed {
		logic [31:0]  addr;
		sfpe_region_e region;
	} sfpe_lock_query_s;

	// low address bits that lie inside one region
	function automatic logic [31:0] sfpe_region_mask(input sfpe_region_e r);
		case (r)
			RG_PAGE:   sfpe_region_mask = (32'h1 << PAGE_LG) - 32'h1;
			RG_SECTOR: sfpe_region_mask = (32'h1 << SECTOR_LG) - 32'h1;
			RG_BLK32:  sfpe_region_mask = (32'h1 << BLK32_LG) - 32'h1;
			RG_BLK64:  sfpe_region_mask = (32'h1 << BLK64_LG) - 32'h1;
			default:   sfpe_region_mask = (32'h1 << ARRAY_AW) - 32'h1;
		endcase
	endfunction

endpackage

// ---- design/sfpe_prot.sv ----
// block-protect range check for one program or erase region
`timescale 1ns/1ns
`default_nettype none
module sfpe_prot (
	input  wire logic                   [31:0] addr,
	input  wire sfpe_pkg::sfpe_region_e        region,
	input  wire logic                          invert,
	input  wire logic                          bottom,
	input  wire logic                   [3:0]  level,
	output logic                               hit
);
	logic [31:0] rfull;
	logic [26:0] rmask;
	logic [26:0] rs;
	logic [26:0] re;
	logic [26:0] plo;
	logic [26:0] phi;
	logic [26:0] span;
	logic [10:0] nblk;
	logic        empty;
	logic        overlap;
	logic        subset;

	always_comb begin
		rfull = sfpe_pkg::sfpe_region_mask(region);
		rmask = rfull[26:0];
		rs    = {1'b0, addr[25:0]} & ~rmask;
		re    = rs | rmask;
		if (level == 4'h0) begin
			nblk = 11'h0;
		end else if (level >= sfpe_pkg::PROT_LVL_CAP) begin
			nblk = sfpe_pkg::PROT_ALL_BLKS;
		end else begin
			nblk = 11'h1 << (level - 4'h1);
		end
		span  = {nblk, 16'h0};
		empty = (nblk == 11'h0);
		if (bottom) begin
			plo = 27'h0;
			phi = span - 27'h1;
		end else begin
			plo = sfpe_pkg::ARRAY_END - span;
			phi = sfpe_pkg::ARRAY_END - 27'h1;
		end
		overlap = !empty && (rs <= phi) && (re >= plo);
		subset  = !empty && (rs >= plo) && (re <= phi);
		// with complement set the listed range is the writable one
		hit = invert ? !subset : overlap;
	end
endmodule
`default_nettype wire

// ---- tb/sfpe_seq_checker.sv ----
// port assertions for the program/erase sequencer
`timescale 1ns/1ns
`default_nettype none
module sfpe_seq_checker #(
	parameter int unsigned PP_CYCLES = 300,
	parameter int unsigned SE_CYCLES = 50
) (
	input wire logic                   clk,
	input wire logic                   rst_b,
	input wire logic                   cs_b,
	input wire logic [3:0]             io_oe,
	input wire sfpe_pkg::sfpe_erase_s  erase_cmd,
	input wire sfpe_pkg::sfpe_mem_wr_s mem_wr,
	input wire logic                   busy,
	input wire logic                   write_enable_latch
);
	logic [31:0]            busy_cnt_r;
	sfpe_pkg::sfpe_region_e region_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) busy_cnt_r <= 32'h0;
		else busy_cnt_r <= busy ? busy_cnt_r + 32'h1 : 32'h0;
	end
	// a cycle without an erase pulse is a program cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) region_r <= sfpe_pkg::RG_PAGE;
		else if (erase_cmd.valid) region_r <= erase_cmd.region;
		else if (!busy) region_r <= sfpe_pkg::RG_PAGE;
	end

	latch_at_start_a: assert property ($rose(busy) |-> write_enable_latch)
		else $error("cycle started without write enable");
	latch_cleared_a: assert property ($fell(busy) |-> !write_enable_latch)
		else $error("write enable still set after cycle");
	pulse_single_a: assert property (erase_cmd.valid |-> busy ##1 !erase_cmd.valid)
		else $error("erase pulse not single or outside busy");
	pulse_idle_a: assert property (erase_cmd.valid |-> $past(busy, 2) == 1'b0)
		else $error("erase started during running cycle");
	sector_base_a: assert property (erase_cmd.valid
		&& erase_cmd.region == sfpe_pkg::RG_SECTOR |-> erase_cmd.base[11:0] == 12'h000)
		else $error("sector base not aligned");
	block_base_a: assert property (erase_cmd.valid
		&& erase_cmd.region == sfpe_pkg::RG_BLK64 |-> erase_cmd.base[15:0] == 16'h0000)
		else $error("block base not aligned");
	sector_time_a: assert property ($fell(busy) && region_r == sfpe_pkg::RG_SECTOR
		|-> busy_cnt_r == SE_CYCLES)
		else $error("sector cycle length wrong");
	program_time_a: assert property ($fell(busy) && region_r == sfpe_pkg::RG_PAGE
		|-> busy_cnt_r >= PP_CYCLES)
		else $error("program cycle too short");
	page_start_a: assert property ($rose(busy) && !erase_cmd.valid
		|=> mem_wr.addr[7:0] == 8'h00)
		else $error("page load not from offset zero");
	load_busy_a: assert property (mem_wr.valid |-> busy)
		else $error("page byte written while idle");
	status_release_a: assert property (cs_b [*6] |-> io_oe == 4'h0)
		else $error("io still driven after deselect");

	cover property (erase_cmd.valid && erase_cmd.region == sfpe_pkg::RG_CHIP);
	cover property ($rose(mem_wr.valid));
	cover property (io_oe == 4'h2 && busy);
endmodule
bind sfpe_seq sfpe_seq_checker #(.PP_CYCLES(PP_CYCLES), .SE_CYCLES(SE_CYCLES)) sfpe_seq_checker_i (
	.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .io_oe(io_oe), .erase_cmd(erase_cmd),
	.mem_wr(mem_wr), .busy(busy), .write_enable_latch(write_enable_latch));
`default_nettype wire

// ---- tb/sfpe_host.sv ----
// host controller model: select, serial clock and io lanes
`timescale 1ns/1ns
`default_nettype none
module sfpe_host (
	input  wire logic       clk,
	input  wire logic       miso,
	output logic            cs_b,
	output logic            sck,
	output logic      [3:0] io
);
	logic [7:0] dq[$];
	logic [7:0] rx;

	initial begin
		cs_b = 1'b1;
		sck  = 1'b0;
		io   = 4'h0;
		rx   = 8'h00;
	end
	// eight clocks a phase leaves the device synchroniser ample margin
	task automatic half();
		repeat (8) @(posedge clk);
	endtask
	task automatic put(input logic [3:0] v);
		io <= v;
		half();
		rx = {rx[6:0], miso};
		sck <= 1'b1;
		half();
		sck <= 1'b0;
	endtask
	// extra rises after the last unit clock out status on a read, or else break the framing on purpose
	task automatic frame(input logic [7:0] op, input logic [31:0] a, input int na,
		input logic quad, input int extra);
		int i;
		cs_b <= 1'b0;
		half();
		for (i = 7; i >= 0; i--) put({3'h0, op[i]});
		for (i = na - 1; i >= 0; i -= quad ? 4 : 1) put(quad ? a[i -: 4] : {3'h0, a[i]});
		foreach (dq[k]) for (i = 7; i >= 0; i -= quad ? 4 : 1) put(quad ? dq[k][i -: 4] : {3'h0, dq[k][i]});
		repeat (extra) put(4'h0);
		half();
		cs_b <= 1'b1;
		io   <= ~io;
		dq.delete();
		half();
		half();
	endtask
endmodule
`default_nettype wire

// ---- tb/serial_flash_program_erase_tb.sv ----
// self-checking bench: host model against the sequencer
`timescale 1ns/1ns
`default_nettype none
module serial_flash_program_erase_tb;
	typedef struct packed {
		logic [7:0]             op;
		logic                   fourb;
		logic [31:0]            addr;
		logic [5:0]             na;
		sfpe_pkg::sfpe_region_e region;
		logic [31:0]            base;
	} sfpe_row_s;
	localparam sfpe_row_s ROWS [8] = '{
		'{8'h20, 1'b0, 32'h00012345, 6'h18, sfpe_pkg::RG_SECTOR, 32'h00012000},
		'{8'h20, 1'b1, 32'h01234567, 6'h20, sfpe_pkg::RG_SECTOR, 32'h01234000},
		'{8'h21, 1'b0, 32'h02345678, 6'h20, sfpe_pkg::RG_SECTOR, 32'h02345000},
		'{8'h52, 1'b0, 32'h0000ABCD, 6'h18, sfpe_pkg::RG_BLK32, 32'h00008000},
		'{8'hD8, 1'b0, 32'h0012FFFF, 6'h18, sfpe_pkg::RG_BLK64, 32'h00120000},
		'{8'hDC, 1'b0, 32'h0345FFFF, 6'h20, sfpe_pkg::RG_BLK64, 32'h03450000},
		'{8'hC7, 1'b0, 32'h00000000, 6'h00, sfpe_pkg::RG_CHIP, 32'h00000000},
		'{8'h60, 1'b1, 32'h00000000, 6'h00, sfpe_pkg::RG_CHIP, 32'h00000000}};

	logic                   clk;
	logic                   rst_b;
	logic                   cs_b;
	logic                   sck;
	logic [3:0]             host_io;
	logic [3:0]             io_in;
	logic [3:0]             io_out;
	logic [3:0]             io_oe;
	logic                   four_byte_mode;
	logic                   quad_io_enable;
	logic [5:0]             prot;
	logic                   lock_hit;
	sfpe_pkg::sfpe_erase_s  erase_cmd;
	sfpe_pkg::sfpe_erase_s  last_er;
	sfpe_pkg::sfpe_mem_wr_s mem_wr;
	sfpe_pkg::sfpe_lock_query_s lock_query;
	logic                   busy;
	logic                   write_enable_latch;
	logic [7:0]             mem [logic [31:0]];
	int                     n_er;
	int                     miscompares;
	int                     n_compared;

	assign io_in = (host_io & ~io_oe) | (io_out & io_oe);
	sfpe_host sfpe_host_i (.clk(clk), .miso(io_in[1]), .cs_b(cs_b), .sck(sck), .io(host_io));
	sfpe_seq #(.PP_CYCLES(2000), .SE_CYCLES(600), .BE32_CYCLES(610), .BE64_CYCLES(620),
		.CE_CYCLES(630)) sfpe_seq_i (
		.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sck(sck), .io_in(io_in), .io_out(io_out),
		.io_oe(io_oe), .four_byte_mode(four_byte_mode), .quad_io_enable(quad_io_enable),
		.protect_complement(prot[5]), .protect_top_bottom(prot[4]),
		.protect_level_bit3(prot[3]), .protect_level_bit2(prot[2]),
		.protect_level_bit1(prot[1]), .protect_level_bit0(prot[0]), .lock_hit(lock_hit),
		.lock_query(lock_query), .erase_cmd(erase_cmd), .mem_wr(mem_wr), .busy(busy),
		.write_enable_latch(write_enable_latch));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (erase_cmd.valid === 1'b1) begin
			last_er <= erase_cmd;
			n_er++;
		end
		if (mem_wr.valid === 1'b1) mem[mem_wr.addr] = mem_wr.data;
	end

	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic idle();
		int i;
		for (i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge clk);
		if (busy !== 1'b0) begin
			miscompares++;
			conclude();
		end
	endtask
	task automatic wren();
		sfpe_host_i.frame(8'h06, 32'h0, 0, 1'b0, 0);
	endtask

	initial begin
		int k;
		int n0;
		rst_b = 1'b0;
		four_byte_mode = 1'b0;
		quad_io_enable = 1'b0;
		prot = 6'h00;
		lock_hit = 1'b0;
		n_er = 0;
		miscompares = 0;
		n_compared = 0;
		repeat (10) @(posedge clk);
		chk("busy", 32'h0, busy);
		chk("wel", 32'h0, write_enable_latch);
		chk("erase valid", 32'h0, erase_cmd.valid);
		chk("io_oe", 32'h0, io_oe);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		for (k = 0; k < 8; k++) begin
			four_byte_mode <= ROWS[k].fourb;
			wren();
			chk("wel", 32'h1, write_enable_latch);
			n0 = n_er;
			sfpe_host_i.frame(ROWS[k].op, ROWS[k].addr, ROWS[k].na, 1'b0, 0);
			chk("busy", 32'h1, busy);
			chk("erase count", n0 + 1, n_er);
			chk("region", ROWS[k].region, last_er.region);
			chk("base", ROWS[k].base, last_er.base);
			chk("query", ROWS[k].addr, lock_query.addr);
			sfpe_host_i.frame(8'h05, 32'h0, 0, 1'b0, 8);
			chk("status", 32'h3, sfpe_host_i.rx);
			idle();
			chk("wel", 32'h0, write_enable_latch);
		end
		four_byte_mode <= 1'b0;
		n0 = n_er;
		sfpe_host_i.frame(8'h20, 32'h1000, 24, 1'b0, 0);
		chk("busy", 32'h0, busy);
		wren();
		sfpe_host_i.frame(8'h20, 32'h1000, 24, 1'b0, 1);
		chk("busy", 32'h0, busy);
		sfpe_host_i.frame(8'hC7, 32'h0, 0, 1'b0, 1);
		chk("busy", 32'h0, busy);
		lock_hit <= 1'b1;
		sfpe_host_i.frame(8'h60, 32'h0, 0, 1'b0, 0);
		chk("busy", 32'h0, busy);
		lock_hit <= 1'b0;
		prot <= 6'h01;
		sfpe_host_i.frame(8'h21, 32'h03FFF000, 32, 1'b0, 0);
		chk("busy", 32'h0, busy);
		chk("erase count", n0, n_er);
		chk("wel", 32'h1, write_enable_latch);
		// complement leaves only the top block open
		prot <= 6'h21;
		sfpe_host_i.frame(8'h21, 32'h03FFF000, 32, 1'b0, 0);
		chk("base", 32'h03FFF000, last_er.base);
		idle();
		prot <= 6'h00;
		wren();
		sfpe_host_i.dq = '{8'hAA, 8'hBB, 8'hCC};
		sfpe_host_i.frame(8'h12, 32'h000001FE, 32, 1'b0, 0);
		idle();
		chk("byte", 32'hAA, mem[32'h1FE]);
		chk("byte", 32'hBB, mem[32'h1FF]);
		chk("byte", 32'hCC, mem[32'h100]);
		chk("wel", 32'h0, write_enable_latch);
		wren();
		sfpe_host_i.dq = '{8'h5A};
		sfpe_host_i.frame(8'h32, 32'h10, 24, 1'b1, 0);
		chk("busy", 32'h0, busy);
		quad_io_enable <= 1'b1;
		sfpe_host_i.dq = '{8'h5A};
		sfpe_host_i.frame(8'h34, 32'h10, 32, 1'b1, 0);
		chk("busy", 32'h1, busy);
		n0 = n_er;
		sfpe_host_i.frame(8'h20, 32'h2000, 24, 1'b0, 0);
		chk("erase count", n0, n_er);
		idle();
		chk("byte", 32'h5A, mem[32'h10]);
		wren();
		sfpe_host_i.frame(8'h04, 32'h0, 0, 1'b0, 0);
		chk("wel", 32'h0, write_enable_latch);
		conclude();
	end
endmodule
`default_nettype wire
